// ---- inc/mrr_pkg.sv ----
// shared constants and types for the serial reply register readout
package mrr_pkg;
    // ==========================================================
    // function codes and exception answers
    localparam logic [7:0] FN_READ_HOLD = 8'h03;
    localparam logic [7:0] FN_WRITE_ONE = 8'h06;
    localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_BAD_FN = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    localparam logic [7:0] EXC_NONE = 8'h00;
    // ==========================================================
    // register map
    localparam logic [15:0] REG_REPLY_CODE_AND_ID = 16'h0001;
    localparam logic [15:0] REG_REPLY_BYTES_3_4 = 16'h0004;
    localparam logic [15:0] REG_CMD_FIRST = 16'h0005;
    localparam logic [15:0] REG_CMD_LAST = 16'h0008;
    localparam logic [15:0] REG_QTY_MAX = 16'h0004;
    localparam logic [7:0] READ_BYTE_COUNT = 8'h08;
    // ==========================================================
    // reply field values and reset values
    localparam logic [7:0] PACKET_ID = 8'hff;
    localparam logic [7:0] RC_BUSY = 8'h10;
    localparam logic [7:0] RC_RESET = 8'h00;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [7:0] DEFAULT_SLAVE = 8'h02;
    // ==========================================================
    // frame check and frame sizes
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    localparam int MIN_FRAME = 4;
    localparam int RX_DEPTH = 20;
    localparam int TX_DEPTH = 11;
    localparam logic [4:0] LEN_FIXED = 5'd8;
    localparam logic [5:0] LEN_MULTI_BASE = 6'd9;
    localparam logic [3:0] TX_LEN_EXC = 4'd3;
    localparam logic [3:0] TX_LEN_ECHO = 4'd6;
    localparam logic [3:0] TX_LEN_READ_BASE = 4'd3;

    typedef enum logic [1:0] {MRR_RX, MRR_EXEC, MRR_TX} mrr_state_t;
endpackage

// ---- rtl/mrr_crc_byte.sv ----
// one byte step of the frame check sequence, lsb first
`timescale 1ns/1ns
module mrr_crc_byte import mrr_pkg::*; (
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data,
    output logic [15:0] crc_out
);
    logic [15:0] stage [0:8];

    assign stage[0] = crc_in ^ {8'h00, data};
    // ==========================================================
    // one shift per data bit
    for (genvar g = 0; g < 8; g++) begin : g_bit
        assign stage[g+1] = stage[g][0] ? ((stage[g] >> 1) ^ CRC_POLY) : (stage[g] >> 1);
    end
    assign crc_out = stage[8];
endmodule

// ---- rtl/mrr_slave.sv ----
// serial register slave holding the reply and taking commands
// Functional notes
// RULE_01 - The block never talks on its own; it only answers a valid request addressed to it.
// RULE_02 - The host fetches the reply by reading registers 1 to 4 in one read with function 03.
// RULE_03 - The host read frame is address, 03, start 00 01, count 00 04, then the check.
// RULE_04 - A full read is answered with address, 03, byte count 08, eight data bytes and check.
// RULE_05 - Reply words are code/0xff, byte0/count, byte2/byte1 and byte4/byte3, high/low.
// RULE_06 - While a command is in progress the reply code reads 0x10.
// RULE_07 - The host polls until the code is 0x00 or an error from 0x30 to 0x36.
// RULE_08 - Command registers are write only; reading them gets an exception answer.
// RULE_09 - Writing the last command word builds the 8-byte command message for the parser.
// RULE_10 - Frames end with the 16-bit check low byte first; a frame that fails it is dropped.
`timescale 1ns/1ns
module mrr_slave import mrr_pkg::*; #(
    parameter logic [7:0] SLAVE_ADDR = DEFAULT_SLAVE
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_frame_end,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic reply_load,
    input wire logic [7:0] reply_code,
    input wire logic [7:0] reply_count,
    input wire logic [39:0] reply_data,
    output logic cmd_valid,
    output logic [63:0] command_message,
    output logic cmd_busy
);
    mrr_state_t state_q, state_d;
    logic [7:0] rx_buf_q [RX_DEPTH];
    logic [7:0] rx_buf_d [RX_DEPTH];
    logic [4:0] rx_len_q, rx_len_d;
    logic ovf_q, ovf_d;
    logic [15:0] rx_crc_q, rx_crc_d, rx_crc_nx;
    logic [7:0] tx_buf_q [TX_DEPTH];
    logic [7:0] tx_buf_d [TX_DEPTH];
    logic [3:0] tx_len_q, tx_len_d, tx_idx_q, tx_idx_d;
    logic [15:0] tx_crc_q, tx_crc_d, tx_crc_nx;
    logic tx_valid_q, tx_valid_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic [15:0] cmd_q [4];
    logic [15:0] cmd_d [4];
    logic cmd_valid_q, cmd_valid_d, issue;
    logic [63:0] msg_q, msg_d;
    logic [7:0] rc_q, rc_d, cnt_q, cnt_d;
    logic [39:0] rdata_q, rdata_d;
    logic busy_q, busy_d;
    logic [7:0] fn, exc;
    logic [15:0] start, qty;
    logic [16:0] fin;
    logic frame_ok, qty_ok, len_ok, addr_ok;

    mrr_crc_byte u_rx_crc (.crc_in(rx_crc_q), .data(rx_data), .crc_out(rx_crc_nx));
    mrr_crc_byte u_tx_crc (.crc_in(tx_crc_q), .data(tx_data_q), .crc_out(tx_crc_nx));

    function automatic logic [15:0] rep_word(input logic [1:0] j);
        case (j)
            2'd0: rep_word = {rc_q, PACKET_ID};
            2'd1: rep_word = {rdata_q[7:0], cnt_q};
            2'd2: rep_word = {rdata_q[23:16], rdata_q[15:8]};
            default: rep_word = {rdata_q[39:32], rdata_q[31:24]};
        endcase
    endfunction

    // ==========================================================
    // request decode
    assign fn = rx_buf_q[1];
    assign start = {rx_buf_q[2], rx_buf_q[3]};
    assign qty = {rx_buf_q[4], rx_buf_q[5]};
    assign fin = {1'b0, start} + {1'b0, qty};
    assign qty_ok = (qty != 16'h0000) && (qty <= REG_QTY_MAX);
    // RULE_10 residue check
    assign frame_ok = !ovf_q && (rx_len_q >= 5'(MIN_FRAME)) && (rx_crc_q == CRC_RESIDUE)
        && (rx_buf_q[0] == SLAVE_ADDR);
    assign len_ok = (fn == FN_WRITE_MULTI) ? (qty_ok && rx_buf_q[6] == {qty[6:0], 1'b0}
        && {1'b0, rx_len_q} == LEN_MULTI_BASE + {2'b00, qty[2:0], 1'b0})
        : (fn == FN_READ_HOLD) ? (qty_ok && rx_len_q == LEN_FIXED) : (rx_len_q == LEN_FIXED);
    // RULE_08 command words are outside the readable window
    assign addr_ok = (fn == FN_READ_HOLD) ? (start >= REG_REPLY_CODE_AND_ID
        && fin <= 17'(REG_REPLY_BYTES_3_4) + 17'd1)
        : (fn == FN_WRITE_MULTI) ? (start >= REG_CMD_FIRST && fin <= 17'(REG_CMD_LAST) + 17'd1)
        : (start >= REG_CMD_FIRST && start <= REG_CMD_LAST);
    assign exc = !(fn == FN_READ_HOLD || fn == FN_WRITE_ONE || fn == FN_WRITE_MULTI) ? EXC_BAD_FN
        : !len_ok ? EXC_BAD_VALUE : !addr_ok ? EXC_BAD_ADDR : EXC_NONE;

    // ==========================================================
    // frame engine
    always_comb begin
        state_d = state_q;
        rx_buf_d = rx_buf_q;
        rx_len_d = rx_len_q;
        ovf_d = ovf_q;
        rx_crc_d = rx_crc_q;
        tx_buf_d = tx_buf_q;
        tx_len_d = tx_len_q;
        tx_idx_d = tx_idx_q;
        tx_crc_d = tx_crc_q;
        tx_valid_d = tx_valid_q;
        tx_data_d = tx_data_q;
        cmd_d = cmd_q;
        issue = 1'b0;
        unique case (state_q)
            MRR_RX: begin
                // frame end wins over a byte in the same cycle
                if (rx_frame_end) begin
                    if (frame_ok) begin
                        state_d = MRR_EXEC;
                    end else begin
                        // RULE_10 failed frames vanish silently
                        rx_len_d = '0;
                        ovf_d = 1'b0;
                        rx_crc_d = CRC_INIT;
                    end
                end else if (rx_valid) begin
                    rx_crc_d = rx_crc_nx;
                    if (rx_len_q == 5'(RX_DEPTH)) begin
                        ovf_d = 1'b1;
                    end else begin
                        rx_buf_d[rx_len_q] = rx_data;
                        rx_len_d = rx_len_q + 5'd1;
                    end
                end
            end
            MRR_EXEC: begin
                rx_len_d = '0;
                ovf_d = 1'b0;
                rx_crc_d = CRC_INIT;
                // RULE_01 transmit only as the answer to a request
                state_d = MRR_TX;
                tx_idx_d = '0;
                tx_crc_d = CRC_INIT;
                tx_valid_d = 1'b1;
                tx_data_d = rx_buf_q[0];
                tx_buf_d[0] = rx_buf_q[0];
                tx_buf_d[1] = fn;
                if (exc != EXC_NONE) begin
                    // RULE_08 exception answer
                    tx_buf_d[1] = fn | EXC_FLAG;
                    tx_buf_d[2] = exc;
                    tx_len_d = TX_LEN_EXC;
                end else if (fn == FN_READ_HOLD) begin
                    // RULE_04 byte count then register data
                    tx_buf_d[2] = {qty[6:0], 1'b0};
                    tx_len_d = TX_LEN_READ_BASE + {qty[2:0], 1'b0};
                    for (int j = 0; j < 4; j++) begin
                        if (16'(j) < qty) begin
                            // RULE_05 high byte first
                            tx_buf_d[3+2*j] = rep_word(2'(start - REG_REPLY_CODE_AND_ID
                                + 16'(j)))[15:8];
                            tx_buf_d[4+2*j] = rep_word(2'(start - REG_REPLY_CODE_AND_ID
                                + 16'(j)))[7:0];
                        end
                    end
                end else begin
                    for (int j = 2; j < 6; j++) begin
                        tx_buf_d[j] = rx_buf_q[j];
                    end
                    tx_len_d = TX_LEN_ECHO;
                    for (int i = 0; i < 4; i++) begin
                        if (fn == FN_WRITE_ONE) begin
                            if (start == REG_CMD_FIRST + 16'(i)) begin
                                cmd_d[i] = qty;
                            end
                        end else if (REG_CMD_FIRST + 16'(i) >= start
                            && 17'(REG_CMD_FIRST) + 17'(i) < fin) begin
                            cmd_d[i] = {rx_buf_q[7+2*(i+5-start)], rx_buf_q[8+2*(i+5-start)]};
                        end
                    end
                    // RULE_09 last command word launches the message
                    issue = (fn == FN_WRITE_ONE) ? (start == REG_CMD_LAST)
                        : (fin == 17'(REG_CMD_LAST) + 17'd1);
                end
            end
            MRR_TX: begin
                if (tx_ready) begin
                    tx_idx_d = tx_idx_q + 4'd1;
                    if (tx_idx_q < tx_len_q) begin
                        tx_crc_d = tx_crc_nx;
                    end
                    // RULE_10 check goes out low byte first
                    if (tx_idx_q + 4'd1 < tx_len_q) begin
                        tx_data_d = tx_buf_q[tx_idx_q+4'd1];
                    end else if (tx_idx_q + 4'd1 == tx_len_q) begin
                        tx_data_d = tx_crc_nx[7:0];
                    end else if (tx_idx_q == tx_len_q) begin
                        tx_data_d = tx_crc_q[15:8];
                    end else begin
                        tx_valid_d = 1'b0;
                        state_d = MRR_RX;
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // reply holding registers and command launch
    always_comb begin
        rc_d = rc_q;
        cnt_d = cnt_q;
        rdata_d = rdata_q;
        busy_d = busy_q;
        msg_d = msg_q;
        cmd_valid_d = issue;
        if (reply_load) begin
            rc_d = reply_code;
            cnt_d = reply_count;
            rdata_d = reply_data;
            busy_d = 1'b0;
        end
        // RULE_06 a new command outranks a reply landing in the same cycle
        if (issue) begin
            rc_d = RC_BUSY;
            busy_d = 1'b1;
            msg_d = {cmd_d[3], cmd_d[2], cmd_d[1], cmd_d[0]};
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= MRR_RX;
            rx_len_q <= '0;
            ovf_q <= 1'b0;
            rx_crc_q <= CRC_INIT;
            tx_len_q <= '0;
            tx_idx_q <= '0;
            tx_crc_q <= CRC_INIT;
            tx_valid_q <= 1'b0;
            tx_data_q <= '0;
            cmd_valid_q <= 1'b0;
            msg_q <= '0;
            rc_q <= RC_RESET;
            cnt_q <= '0;
            rdata_q <= '0;
            busy_q <= 1'b0;
            for (int i = 0; i < RX_DEPTH; i++) rx_buf_q[i] <= '0;
            for (int i = 0; i < TX_DEPTH; i++) tx_buf_q[i] <= '0;
            for (int i = 0; i < 4; i++) cmd_q[i] <= CMD_RESET;
        end else begin
            state_q <= state_d;
            rx_len_q <= rx_len_d;
            ovf_q <= ovf_d;
            rx_crc_q <= rx_crc_d;
            tx_len_q <= tx_len_d;
            tx_idx_q <= tx_idx_d;
            tx_crc_q <= tx_crc_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q <= tx_data_d;
            cmd_valid_q <= cmd_valid_d;
            msg_q <= msg_d;
            rc_q <= rc_d;
            cnt_q <= cnt_d;
            rdata_q <= rdata_d;
            busy_q <= busy_d;
            rx_buf_q <= rx_buf_d;
            tx_buf_q <= tx_buf_d;
            cmd_q <= cmd_d;
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
    assign cmd_valid = cmd_valid_q;
    assign command_message = msg_q;
    assign cmd_busy = busy_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_no_unsolicited_tx: assert property ($rose(tx_valid_q) |-> $past(state_q) == MRR_EXEC) // RULE_01
        else $error("transmit started without a request");
    a_answer_addr_first: assert property (state_q == MRR_EXEC |=> tx_valid_q
        && tx_data_q == $past(rx_buf_q[0]) && tx_idx_q == 4'd0) // RULE_04
        else $error("answer does not open with slave address");
    a_full_read_count: assert property (state_q == MRR_EXEC && exc == EXC_NONE
        && fn == FN_READ_HOLD && qty == REG_QTY_MAX
        |=> tx_buf_q[2] == READ_BYTE_COUNT && tx_len_q == 4'd11) // RULE_04
        else $error("full read byte count wrong");
    a_pid_layout: assert property (state_q == MRR_EXEC && exc == EXC_NONE && fn == FN_READ_HOLD
        && start == REG_REPLY_CODE_AND_ID |=> tx_buf_q[4] == PACKET_ID
        && tx_buf_q[3] == $past(rc_q)) // RULE_05
        else $error("first reply word layout wrong");
    a_busy_code: assert property (cmd_valid_q |-> rc_q == RC_BUSY && busy_q) // RULE_06
        else $error("command issued without busy code");
    a_cmd_message: assert property (cmd_valid_q |-> command_message
        == {cmd_q[3], cmd_q[2], cmd_q[1], cmd_q[0]} ##1 !cmd_valid_q) // RULE_09
        else $error("command message does not match command words");
    a_cmd_read_refused: assert property (state_q == MRR_EXEC && fn == FN_READ_HOLD && qty_ok
        && rx_len_q == LEN_FIXED && start >= REG_CMD_FIRST
        |=> tx_buf_q[1] == (FN_READ_HOLD | EXC_FLAG) && tx_buf_q[2] == EXC_BAD_ADDR) // RULE_08
        else $error("command register read not refused");
    a_bad_crc_dropped: assert property (state_q == MRR_RX && rx_frame_end
        && rx_crc_q != CRC_RESIDUE |=> state_q == MRR_RX && !tx_valid_q) // RULE_10
        else $error("frame with bad check was answered");
endmodule

// ---- tb/mrr_host_model.sv ----
// host controller model: sends request frames, collects answer bytes
`timescale 1ns/1ns
module mrr_host_model (
    input wire logic clk_sys,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_frame_end,
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data
);
    logic slow = 1'b0;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_frame_end = 1'b0;
        tx_ready = 1'b0;
    end

    // ==========================================================
    // frame check
    // reflected crc16
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction

    // ==========================================================
    // request side
    // whole frame, check low first
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(posedge clk_sys);
            #1;
            rx_valid = 1'b1;
            rx_data = f[i];
        end
        @(posedge clk_sys);
        #1;
        rx_valid = 1'b0;
        // released line shows the inverse, not the last byte
        rx_data = ~rx_data;
        rx_frame_end = 1'b1;
        @(posedge clk_sys);
        #1;
        rx_frame_end = 1'b0;
    endtask

    // ==========================================================
    // answer side
    // one poll: fixed window, stalls when slow
    task automatic get(output logic [7:0] a[$]);
        a = {};
        for (int n = 0; n < 60; n++) begin
            @(posedge clk_sys);
            #1;
            // last step of the window lowers ready so no byte is counted but left untaken
            tx_ready = (n == 59) ? 1'b0 : slow ? 1'($urandom_range(0, 1)) : 1'b1;
            if (tx_valid && tx_ready) a.push_back(tx_data);
        end
    endtask
endmodule

// ---- tb/serial_reply_register_readout_test.sv ----
// self-checking bench for the serial reply register slave
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module serial_reply_register_readout_test import mrr_pkg::*;;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic rx_valid, rx_frame_end, tx_ready, tx_valid, cmd_valid, cmd_busy;
    logic [7:0] rx_data, tx_data;
    logic reply_load = 1'b0;
    logic [7:0] reply_code = 8'h00;
    logic [7:0] reply_count = 8'h00;
    logic [39:0] reply_data = 40'h0;
    logic [63:0] command_message, msg;
    logic [7:0] e[$], g[$], w[$];
    logic [7:0] ref_code = 8'h00;
    logic [7:0] ref_cnt = 8'h00;
    logic [7:0] ref_data[5] = '{default: 8'h00};
    int fails = 0;
    int checked = 0;
    int pulses = 0;

    mrr_slave i_mrr_slave (.clk_sys(clk_sys), .nrst(nrst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .reply_load(reply_load),
        .reply_code(reply_code), .reply_count(reply_count), .reply_data(reply_data),
        .cmd_valid(cmd_valid), .command_message(command_message), .cmd_busy(cmd_busy));
    mrr_host_model i_mrr_host_model (.clk_sys(clk_sys), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data));

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (cmd_valid === 1'b1) begin
            pulses++;
            msg = command_message;
        end
    end

    // ==========================================================
    // helpers
    task automatic final_report();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp_ans(input string nm);
        logic [15:0] c;
        c = i_mrr_host_model.crc16(e);
        if (e.size() > 0) e = {e, c[7:0], c[15:8]};
        `CHK({nm, " length"}, e.size(), g.size())
        foreach (e[i]) if (i < g.size()) `CHK(nm, e[i], g[i])
    endtask

    task automatic xfer(input logic [7:0] f[$], input logic bad);
        i_mrr_host_model.send(f, bad);
        i_mrr_host_model.get(g);
    endtask

    task automatic poll(input string nm);
        xfer({8'h02, 8'h03, 8'h00, 8'h01, 8'h00, 8'h04}, 1'b0);
        e = {8'h02, 8'h03, 8'h08, ref_code, 8'hff, ref_data[0], ref_cnt,
            ref_data[2], ref_data[1], ref_data[4], ref_data[3]};
        cmp_ans(nm);
    endtask

    initial begin
        #200000;
        fails++;
        final_report();
    end

    initial begin
        void'($urandom(34));
        repeat (10) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        i_mrr_host_model.get(g);
        `CHK("unasked bytes", 0, g.size())
        poll("reset read");
        i_mrr_host_model.slow = 1'b1;
        w = {8'h02, 8'h10, 8'h00, 8'h05, 8'h00, 8'h04, 8'h08};
        repeat (8) w.push_back(8'($urandom));
        xfer(w, 1'b0);
        e = w[0:5];
        cmp_ans("write echo");
        `CHK("cmd pulses", 1, pulses)
        `CHK("cmd message", {w[13], w[14], w[11], w[12], w[9], w[10], w[7], w[8]}, msg)
        `CHK("busy flag", 1'b1, cmd_busy)
        ref_code = 8'h10;
        poll("busy read");
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            #1;
            reply_load = 1'b1;
            reply_code = k == 0 ? 8'h00 : 8'(8'h2f + k);
            reply_count = 8'($urandom);
            reply_data = {8'($urandom), 32'($urandom)};
            ref_code = reply_code;
            ref_cnt = reply_count;
            foreach (ref_data[n]) ref_data[n] = reply_data[8 * n +: 8];
            @(posedge clk_sys);
            #1;
            reply_load = 1'b0;
            `CHK("busy cleared", 1'b0, cmd_busy)
            poll("reply read");
        end
        xfer({8'h02, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, 1'b0);
        e = {8'h02, 8'h83, 8'h02};
        cmp_ans("read of command");
        xfer({8'h02, 8'h03, 8'h00, 8'h01, 8'h00, 8'h04}, 1'b1);
        `CHK("bad check answer", 0, g.size())
        xfer({8'h03, 8'h03, 8'h00, 8'h01, 8'h00, 8'h04}, 1'b0);
        `CHK("other slave answer", 0, g.size())
        poll("final read");
        final_report();
    end
endmodule
